// ===== sst_pkg.sv
/*
  shared constants and types of the sync serial core.
  assumes nothing beyond a SystemVerilog compiler; imported by the core and the bench, not by the buffer, interface or codec model.
*/
`default_nettype none
package sst_pkg;
  localparam int DIV_W = 12;
  localparam int WORD_W = 32;
  localparam int SYNC_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [DIV_W-1:0] DIV_OFF = 12'h000;
  localparam logic [DIV_W-1:0] DIV_STEP = 12'h001;

  typedef enum logic [1:0] {
    CKS_DIV = 2'h0,
    CKS_OTHER = 2'h1,
    CKS_PIN = 2'h2
  } sst_cks_e;

  typedef enum logic [1:0] {
    CKO_OFF = 2'h0,
    CKO_CONT = 2'h1,
    CKO_XFER = 2'h2
  } sst_cko_e;

  typedef enum logic [2:0] {
    ST_CONT = 3'h0,
    ST_SYNC = 3'h1,
    ST_FALL = 3'h2,
    ST_RISE = 3'h3,
    ST_LOW = 3'h4,
    ST_HIGH = 3'h5,
    ST_ANY = 3'h6,
    ST_CMP = 3'h7
  } sst_start_e;

  typedef enum logic [2:0] {
    FS_INPUT = 3'h0,
    FS_LOW_DATA = 3'h1,
    FS_HIGH_DATA = 3'h2,
    FS_PULSE = 3'h3,
    FS_TOGGLE = 3'h4
  } sst_frame_sync_output_select_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_ARMED = 2'h1,
    PH_DELAY = 2'h2,
    PH_DATA = 2'h3
  } sst_phase_e;
endpackage
`default_nettype wire

// ===== sst_fifo_if.sv
/*
  valid/ready carrier between the core and its transmit word buffer.
  assumes both ends run on the same master clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface sst_fifo_if #(
  parameter int W = 32
) ();
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;

  modport fifo (input push_valid, input push_data, input pop_ready, output push_ready, output pop_valid, output pop_data);
  modport user (output push_valid, output push_data, output pop_ready, input push_ready, input pop_valid, input pop_data);
endinterface
`default_nettype wire

// ===== sst_fifo.sv
/*
  word buffer with registered read data and registered ready.
  assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sst_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  sst_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] dout;
    logic dvalid;
    logic rdy;
  } sst_fifo_s;

  sst_fifo_s s;
  sst_fifo_s n;
  logic push;
  logic pop;
  logic take;

  // the output word counts toward the depth, so full means DEPTH words in total
  always_comb
  begin
    n = s;
    push = f.push_valid & s.rdy;
    pop = f.pop_ready & s.dvalid;
    take = (s.cnt != '0) & (~s.dvalid | pop);
    if (push)
    begin
      n.mem[s.wptr] = f.push_data;
      n.wptr = s.wptr + AW'(1);
    end
    if (take)
    begin
      n.dout = s.mem[s.rptr];
      n.rptr = s.rptr + AW'(1);
      n.dvalid = 1'b1;
    end
    else if (pop)
    begin
      n.dvalid = 1'b0;
    end
    n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
    n.rdy = (n.cnt + {{AW{1'b0}}, n.dvalid}) < (AW+1)'(DEPTH);
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      s <= '0;
    else
      s <= n;
  end

  assign f.push_ready = s.rdy;
  assign f.pop_valid = s.dvalid;
  assign f.pop_data = s.dout;
endmodule
`default_nettype wire

// ===== sst_core.sv
/*
  sync serial core: shared divider, bit clock choice, framing, holding and shift registers, status flags.
  assumes pin inputs synchronous to i_mclk and pin wires resolved outside from the enables.
*/
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// (R1) 12-bit ratio feeds shared divider; zero idles
// (R2) each divided level lasts ratio master cycles
// (R3) transmit clock from pin, receive or divider
// (R4) receive clock from pin, transmit or divider
// (R5) inversion affects internal clock, never the pin
// (R6) clock pin driven always or during data
// (R7) software avoids pin source with continuous output
// (R8) receive pin clock limited by frame direction
// (R9) transmit pin clock limited by frame direction
// (R10) load frees holding; both empty means drained
// (R11) transmit shifter loads holding word per format
// (R12) full receive word copied, full flag set
// (R13) unread word replaced, overwrite flag set
// (R14) continuous start: on written word or enable
// (R15) start on other side, edge, level, change
// (R16) receiver may start on compare pattern
// (R17) frame pin waveform chosen per direction
// (R18) pulse width is one to sixteen bits
// (R19) period field sets frame pulse interval
// (R20) sync bits sampled or shifted during sync
// (R21) sync data only when enabled; data wins
// (R22) receive sync bits pass through shift register
// (R23) chosen frame edge sets sync seen flag
module sst_core (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [sst_pkg::DIV_W-1:0] i_div_ratio,
  input wire sst_pkg::sst_cks_e i_tx_cks,
  input wire sst_pkg::sst_cks_e i_rx_cks,
  input wire logic i_tx_cki,
  input wire logic i_rx_cki,
  input wire sst_pkg::sst_cko_e i_tx_cko,
  input wire sst_pkg::sst_cko_e i_rx_cko,
  input wire sst_pkg::sst_start_e i_tx_start,
  input wire sst_pkg::sst_start_e i_rx_start,
  input wire sst_pkg::sst_frame_sync_output_select_e i_tx_frame_sync_output_select,
  input wire sst_pkg::sst_frame_sync_output_select_e i_rx_frame_sync_output_select,
  input wire logic [3:0] i_tx_sync_length,
  input wire logic [3:0] i_rx_sync_length,
  input wire logic [7:0] i_tx_sttdly,
  input wire logic [7:0] i_rx_sttdly,
  input wire logic [7:0] i_tx_period,
  input wire logic [7:0] i_rx_period,
  input wire logic [4:0] i_tx_datlen,
  input wire logic [4:0] i_rx_datlen,
  input wire logic i_tx_sync_data_enable,
  input wire logic i_tx_datdef,
  input wire logic i_tx_sync_edge_select,
  input wire logic i_rx_sync_edge_select,
  input wire logic i_tx_enable,
  input wire logic i_rx_enable,
  input wire logic [sst_pkg::SYNC_W-1:0] i_tx_sync_word,
  input wire logic [sst_pkg::SYNC_W-1:0] i_rx_compare,
  input wire logic i_tx_valid,
  input wire logic [sst_pkg::WORD_W-1:0] i_tx_word,
  output logic o_tx_ready,
  output logic [sst_pkg::WORD_W-1:0] o_rx_word,
  output logic [sst_pkg::SYNC_W-1:0] o_rx_sync_word,
  input wire logic i_rx_read,
  input wire logic i_status_clear,
  output logic o_tx_holding_free,
  output logic o_tx_drained,
  output logic o_rx_holding_full,
  output logic o_rx_overwrite,
  output logic o_tx_sync_seen,
  output logic o_rx_sync_seen,
  input wire logic i_tx_clk_pin,
  output logic o_tx_clk_pin,
  output logic o_tx_clk_oe,
  input wire logic i_rx_clk_pin,
  output logic o_rx_clk_pin,
  output logic o_rx_clk_oe,
  input wire logic i_tx_frame_pin,
  output logic o_tx_frame_pin,
  output logic o_tx_frame_oe,
  input wire logic i_rx_frame_pin,
  output logic o_rx_frame_pin,
  output logic o_rx_frame_oe,
  output logic o_tx_data_pin,
  input wire logic i_rx_data_pin
);
  import sst_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] dcnt;
    logic dclk;
    logic tci;
    logic rci;
    logic tfq;
    logic rfq;
    sst_phase_e tph;
    sst_phase_e rph;
    logic [7:0] tfc;
    logic [7:0] rfc;
    logic [4:0] tbc;
    logic [4:0] rbc;
    logic [7:0] tper;
    logic [7:0] rper;
    logic [WORD_W-1:0] tsr;
    logic [WORD_W-1:0] rsr;
    logic [WORD_W-1:0] thr;
    logic [WORD_W-1:0] rhr;
    logic [SYNC_W-1:0] rhist;
    logic [SYNC_W-1:0] rshr;
    logic thr_full;
    logic rhr_full;
    logic rovr;
    logic tsyn;
    logic rsyn;
    logic tsg;
    logic rsg;
    logic ttog;
    logic rtog;
    logic tfree;
    logic tdrn;
    logic td;
    logic tfs;
    logic rfs;
    logic tfs_oe;
    logic rfs_oe;
    logic tclk_o;
    logic tclk_oe;
    logic rclk_o;
    logic rclk_oe;
  } sst_core_s;

  sst_core_s s;
  sst_core_s n;
  sst_fifo_if #(.W(WORD_W)) fif ();
  logic tx_base;
  logic rx_base;
  logic tclk;
  logic rclk;
  logic ttick;
  logic rtick;
  logic tsyn_ev;
  logic rsyn_ev;
  logic tper_hit;
  logic rper_hit;
  logic cmp_hit;
  logic tgo;
  logic rgo;
  logic tload;
  logic rdone;
  logic [SYNC_W-1:0] hist;
  logic [SYNC_W-1:0] m16;
  logic [WORD_W-1:0] m32;

  function automatic logic start_hit(input sst_start_e m, input logic prev, input logic cur,
                                     input logic other, input logic cmp);
    case (m)
      ST_SYNC: start_hit = other;
      ST_FALL: start_hit = prev & ~cur;
      ST_RISE: start_hit = ~prev & cur;
      ST_LOW: start_hit = ~cur;
      ST_HIGH: start_hit = cur;
      ST_ANY: start_hit = prev ^ cur;
      ST_CMP: start_hit = cmp;
      default: start_hit = 1'b0;
    endcase
  endfunction

  function automatic logic fs_wave(input sst_frame_sync_output_select_e m, input logic dat, input logic syn, input logic tog);
    case (m)
      FS_LOW_DATA: fs_wave = ~dat;
      FS_HIGH_DATA: fs_wave = dat;
      FS_PULSE: fs_wave = syn;
      FS_TOGGLE: fs_wave = tog;
      default: fs_wave = 1'b0;
    endcase
  endfunction

  sst_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .f(fif)
  );

  assign fif.push_valid = i_tx_valid;
  assign fif.push_data = i_tx_word;

  always_comb
  begin
    n = s;
    tload = 1'b0;
    rdone = 1'b0;
    tper_hit = 1'b0;
    rper_hit = 1'b0;
    fif.pop_ready = 1'b0;
    n.tsg = 1'b0;
    n.rsg = 1'b0;
    if (i_div_ratio == DIV_OFF) // see (R1)
    begin
      n.dcnt = DIV_OFF;
      n.dclk = 1'b0;
    end
    else if (s.dcnt == i_div_ratio - DIV_STEP) // see (R2)
    begin
      n.dcnt = DIV_OFF;
      n.dclk = ~s.dclk;
    end
    else
    begin
      n.dcnt = s.dcnt + DIV_STEP;
    end
    // the cross choice takes the other side's own source, so mutual selection cannot loop
    tx_base = (i_tx_cks == CKS_PIN) ? i_tx_clk_pin : s.dclk;
    rx_base = (i_rx_cks == CKS_PIN) ? i_rx_clk_pin : s.dclk;
    tclk = (i_tx_cks == CKS_OTHER) ? rx_base : tx_base; // see (R3)
    rclk = (i_rx_cks == CKS_OTHER) ? tx_base : rx_base; // see (R4)
    ttick = s.tci & ~(tclk ^ i_tx_cki); // see (R5)
    rtick = ~s.rci & (rclk ^ i_rx_cki); // see (R5)
    n.tci = tclk ^ i_tx_cki;
    n.rci = rclk ^ i_rx_cki;
    n.tfq = i_tx_frame_pin;
    n.rfq = i_rx_frame_pin;
    tsyn_ev = i_tx_sync_edge_select ? (s.tfq & ~i_tx_frame_pin) : (~s.tfq & i_tx_frame_pin);
    rsyn_ev = i_rx_sync_edge_select ? (s.rfq & ~i_rx_frame_pin) : (~s.rfq & i_rx_frame_pin);
    n.tsyn = tsyn_ev | (s.tsyn & ~i_status_clear); // see (R23)
    n.rsyn = rsyn_ev | (s.rsyn & ~i_status_clear); // see (R23)
    if (ttick && i_tx_period != 8'h00) // see (R19)
    begin
      tper_hit = s.tper == i_tx_period;
      n.tper = tper_hit ? 8'h00 : s.tper + 8'h01;
    end
    if (rtick && i_rx_period != 8'h00) // see (R19)
    begin
      rper_hit = s.rper == i_rx_period;
      n.rper = rper_hit ? 8'h00 : s.rper + 8'h01;
    end
    hist = rtick ? {s.rhist[SYNC_W-2:0], i_rx_data_pin} : s.rhist;
    n.rhist = hist;
    m16 = ~(16'hfffe << i_rx_sync_length);
    m32 = ~(32'hffff_fffe << i_rx_datlen);
    cmp_hit = rtick & (((hist ^ i_rx_compare) & m16) == 16'h0000); // see (R16)
    // other-side starts are registered one cycle to break the tx/rx start loop
    tgo = (i_tx_start == ST_CONT) ? s.thr_full :
          (start_hit(i_tx_start, s.tfq, i_tx_frame_pin, s.rsg, 1'b0) | tper_hit); // see (R14) (R15)
    rgo = (i_rx_start == ST_CONT) ? 1'b1 :
          (start_hit(i_rx_start, s.rfq, i_rx_frame_pin, s.tsg, cmp_hit) | rper_hit); // see (R14) (R15)

    case (s.tph)
      PH_IDLE:
        if (i_tx_enable)
          n.tph = PH_ARMED;
      PH_ARMED:
        if (tgo)
        begin
          n.tsg = 1'b1;
          n.ttog = ~s.ttog;
          n.tfc = 8'h00;
          if (i_tx_sttdly == 8'h00)
            tload = 1'b1;
          else
            n.tph = PH_DELAY;
        end
      PH_DELAY:
        if (ttick)
        begin
          n.tfc = s.tfc + 8'h01;
          if (n.tfc == i_tx_sttdly)
            tload = 1'b1;
        end
      PH_DATA:
        if (ttick) // see (R11)
        begin
          if (s.tfc != 8'hff)
            n.tfc = s.tfc + 8'h01;
          n.tsr = s.tsr << 1;
          n.tbc = s.tbc + 5'h01;
          if (s.tbc == i_tx_datlen)
            n.tph = PH_ARMED;
        end
      default:
        n.tph = PH_IDLE;
    endcase
    if (tload) // see (R11) (R10)
    begin
      n.tph = PH_DATA;
      n.tbc = 5'h00;
      n.tsr = s.thr_full ? s.thr : {WORD_W{i_tx_datdef}};
      n.thr_full = 1'b0;
    end
    if (!s.thr_full && fif.pop_valid)
    begin
      fif.pop_ready = 1'b1;
      n.thr = fif.pop_data;
      n.thr_full = 1'b1;
    end
    if (!i_tx_enable)
      n.tph = PH_IDLE;
    n.tfree = ~n.thr_full; // see (R10)
    n.tdrn = ~n.thr_full & (n.tph != PH_DATA); // see (R10)
    // sync bits only fill the start delay; the first data bit always takes over
    if (n.tph == PH_DATA)
      n.td = n.tsr[i_tx_datlen];
    else if (n.tph == PH_DELAY && i_tx_sync_data_enable && n.tfc <= {4'h0, i_tx_sync_length}) // see (R20) (R21)
      n.td = i_tx_sync_word[i_tx_sync_length - n.tfc[3:0]];
    else
      n.td = i_tx_datdef;
    n.tfs = fs_wave(i_tx_frame_sync_output_select, n.tph == PH_DATA,
                    (n.tph == PH_DELAY || n.tph == PH_DATA) && n.tfc <= {4'h0, i_tx_sync_length}, n.ttog); // see (R17) (R18)
    n.tfs_oe = i_tx_frame_sync_output_select != FS_INPUT;
    n.tclk_o = tclk;
    n.tclk_oe = (i_tx_cko == CKO_CONT) || (i_tx_cko == CKO_XFER && n.tph == PH_DATA); // see (R6)

    case (s.rph)
      PH_IDLE:
        if (i_rx_enable)
          n.rph = PH_ARMED;
      PH_ARMED:
        if (rgo)
        begin
          n.rsg = 1'b1;
          n.rtog = ~s.rtog;
          n.rfc = 8'h00;
          n.rbc = 5'h00;
          n.rph = (i_rx_sttdly == 8'h00) ? PH_DATA : PH_DELAY;
        end
      PH_DELAY:
        if (rtick)
        begin
          n.rfc = s.rfc + 8'h01;
          n.rsr = {s.rsr[WORD_W-2:0], i_rx_data_pin};
          if (s.rfc == {4'h0, i_rx_sync_length}) // see (R20) (R22)
            n.rshr = n.rsr[SYNC_W-1:0] & m16;
          if (n.rfc == i_rx_sttdly)
            n.rph = PH_DATA;
        end
      PH_DATA:
        if (rtick)
        begin
          if (s.rfc != 8'hff)
            n.rfc = s.rfc + 8'h01;
          n.rsr = {s.rsr[WORD_W-2:0], i_rx_data_pin};
          n.rbc = s.rbc + 5'h01;
          if (s.rbc == i_rx_datlen)
          begin
            rdone = 1'b1;
            n.rbc = 5'h00;
            if (i_rx_start != ST_CONT)
              n.rph = PH_ARMED;
          end
        end
      default:
        n.rph = PH_IDLE;
    endcase
    if (!i_rx_enable)
      n.rph = PH_IDLE;
    if (rdone) // see (R12)
      n.rhr = n.rsr & m32;
    n.rhr_full = rdone | (s.rhr_full & ~i_rx_read); // see (R12)
    n.rovr = (rdone & s.rhr_full & ~i_rx_read) | (s.rovr & ~i_status_clear); // see (R13)
    n.rfs = fs_wave(i_rx_frame_sync_output_select, n.rph == PH_DATA,
                    (n.rph == PH_DELAY || n.rph == PH_DATA) && n.rfc <= {4'h0, i_rx_sync_length}, n.rtog); // see (R17) (R18)
    n.rfs_oe = i_rx_frame_sync_output_select != FS_INPUT;
    n.rclk_o = rclk;
    n.rclk_oe = (i_rx_cko == CKO_CONT) || (i_rx_cko == CKO_XFER && n.rph == PH_DATA); // see (R6)
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
      s <= '0;
    else
      s <= n;
  end

  assign o_tx_ready = fif.push_ready;
  assign o_rx_word = s.rhr;
  assign o_rx_sync_word = s.rshr;
  assign o_tx_holding_free = s.tfree;
  assign o_tx_drained = s.tdrn;
  assign o_rx_holding_full = s.rhr_full;
  assign o_rx_overwrite = s.rovr;
  assign o_tx_sync_seen = s.tsyn;
  assign o_rx_sync_seen = s.rsyn;
  assign o_tx_clk_pin = s.tclk_o;
  assign o_tx_clk_oe = s.tclk_oe;
  assign o_rx_clk_pin = s.rclk_o;
  assign o_rx_clk_oe = s.rclk_oe;
  assign o_tx_frame_pin = s.tfs;
  assign o_tx_frame_oe = s.tfs_oe;
  assign o_rx_frame_pin = s.rfs;
  assign o_rx_frame_oe = s.rfs_oe;
  assign o_tx_data_pin = s.td;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  div_idle_a: // see (R1)
    assert property (i_div_ratio == DIV_OFF |=> !s.dclk)
    else $error("divided clock moves with ratio zero");
  div_level_a: // see (R2)
    assert property ($rose(s.dclk) ##0 (i_div_ratio == 12'h003) [*3] |-> $past(s.dclk) && s.dclk ##1 !s.dclk)
    else $error("divided clock level not three cycles");
  clk_pin_a: // see (R5)
    assert property (i_tx_cks == CKS_DIV |=> o_tx_clk_pin == $past(s.dclk))
    else $error("transmit clock pin not the plain divided clock");
  clk_cont_a: // see (R6)
    assert property (i_rx_cko == CKO_CONT |=> o_rx_clk_oe)
    else $error("receive clock pin not driven in continuous mode");
  tx_free_a: // see (R10)
    assert property (tload && s.thr_full |=> o_tx_holding_free)
    else $error("holding free flag missing after load");
  rx_full_a: // see (R12)
    assert property (rdone |=> o_rx_holding_full ##1 (o_rx_holding_full || $past(i_rx_read)))
    else $error("receive full flag missing after word");
  rx_ovr_a: // see (R13)
    assert property (rdone && s.rhr_full && !i_rx_read |=> o_rx_overwrite && o_rx_holding_full)
    else $error("overwrite flag missing");
  rx_cont_a: // see (R14)
    assert property (s.rph == PH_ARMED && i_rx_enable && i_rx_start == ST_CONT |=> s.rph != PH_ARMED)
    else $error("continuous receive did not start");
  fs_high_a: // see (R17)
    assert property ($past(i_tx_frame_sync_output_select) == FS_HIGH_DATA |-> o_tx_frame_pin == (s.tph == PH_DATA))
    else $error("transmit frame pin not high during data");
  sync_seen_a: // see (R23)
    assert property (rsyn_ev |=> o_rx_sync_seen)
    else $error("receive sync seen flag missing");

  cover property (rdone && s.rhr_full);
  cover property (tload && s.thr_full);
  cover property (cmp_hit && s.rph == PH_ARMED && i_rx_start == ST_CMP);
endmodule
`default_nettype wire

// ===== sst_codec_model.sv
/*
  external codec model: listens on the transmit pins and sends framed words on the receive pins.
  assumes the bench resolves the pads and calls send_frame at a falling master clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module sst_codec_model #(
  parameter int HALF_NS = 400 // eight master cycles a level, under the mclk/2 limit
) (
  input wire logic i_tx_clk,
  input wire logic i_tx_data,
  output logic o_rx_clk,
  output logic o_rx_frame,
  output logic o_rx_data,
  output logic [63:0] o_tx_capture
);
  initial
  begin
    o_rx_clk = 1'b0;
    o_rx_frame = 1'b0;
    o_rx_data = 1'b0;
    o_tx_capture = '0;
  end

  // listener keeps a history; the bench looks for the expected bits anywhere in it
  always @(posedge i_tx_clk)
  begin
    o_tx_capture <= {o_tx_capture[62:0], i_tx_data};
  end

  // clock stands low outside frames; data goes to the inverse of the last bit once released
  task automatic send_frame(input logic [15:0] bits, input int nbits, input int fsbits);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      o_rx_data = bits[i];
      o_rx_frame = (i >= nbits - fsbits);
      #(HALF_NS);
      o_rx_clk = 1'b1;
      #(HALF_NS);
      o_rx_clk = 1'b0;
    end
    o_rx_frame = 1'b0;
    o_rx_data = ~bits[0];
  endtask
endmodule
`default_nettype wire

// ===== sync_serial_tx_rx_core_test.sv
/*
  self-checking bench for the sync serial core with a codec model on its pins.
  assumes the package constants and the encodings given by the core's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_serial_tx_rx_core_test;
  import sst_pkg::*;
  logic i_mclk, i_rstn, i_tx_cki, i_rx_cki, i_tx_sync_data_enable, i_tx_datdef, i_tx_sync_edge_select, i_rx_sync_edge_select;
  logic [DIV_W-1:0] i_div_ratio;
  sst_cks_e i_tx_cks, i_rx_cks;
  sst_cko_e i_tx_cko, i_rx_cko;
  sst_start_e i_tx_start, i_rx_start;
  sst_frame_sync_output_select_e i_tx_frame_sync_output_select, i_rx_frame_sync_output_select;
  logic [3:0] i_tx_sync_length, i_rx_sync_length;
  logic [7:0] i_tx_sttdly, i_rx_sttdly, i_tx_period, i_rx_period;
  logic [4:0] i_tx_datlen, i_rx_datlen;
  logic i_tx_enable, i_rx_enable, i_tx_valid, o_tx_ready, i_rx_read, i_status_clear;
  logic [SYNC_W-1:0] i_tx_sync_word, i_rx_compare, o_rx_sync_word;
  logic [WORD_W-1:0] i_tx_word, o_rx_word;
  logic o_tx_holding_free, o_tx_drained, o_rx_holding_full, o_rx_overwrite, o_tx_sync_seen, o_rx_sync_seen;
  logic o_tx_clk_pin, o_tx_clk_oe, o_rx_clk_pin, o_rx_clk_oe, o_tx_frame_pin, o_tx_frame_oe;
  logic o_rx_frame_pin, o_rx_frame_oe, o_tx_data_pin, codec_rk, codec_rf, codec_rd;
  logic [63:0] cap;
  wire i_tx_clk_pin, i_rx_clk_pin, i_tx_frame_pin, i_rx_frame_pin, i_rx_data_pin;
  int fails, checks, cyc;

  // released pads are pulled low unless the codec drives them
  assign i_tx_clk_pin = o_tx_clk_oe ? o_tx_clk_pin : 1'b0;
  assign i_rx_clk_pin = o_rx_clk_oe ? o_rx_clk_pin : codec_rk;
  assign i_tx_frame_pin = o_tx_frame_oe ? o_tx_frame_pin : 1'b0;
  assign i_rx_frame_pin = o_rx_frame_oe ? o_rx_frame_pin : codec_rf;
  assign i_rx_data_pin = codec_rd;

  sst_core dut (.i_mclk, .i_rstn, .i_div_ratio, .i_tx_cks, .i_rx_cks, .i_tx_cki, .i_rx_cki, .i_tx_cko,
    .i_rx_cko, .i_tx_start, .i_rx_start, .i_tx_frame_sync_output_select, .i_rx_frame_sync_output_select, .i_tx_sync_length, .i_rx_sync_length, .i_tx_sttdly,
    .i_rx_sttdly, .i_tx_period, .i_rx_period, .i_tx_datlen, .i_rx_datlen, .i_tx_sync_data_enable, .i_tx_datdef,
    .i_tx_sync_edge_select, .i_rx_sync_edge_select, .i_tx_enable, .i_rx_enable, .i_tx_sync_word, .i_rx_compare, .i_tx_valid,
    .i_tx_word, .o_tx_ready, .o_rx_word, .o_rx_sync_word, .i_rx_read, .i_status_clear, .o_tx_holding_free,
    .o_tx_drained, .o_rx_holding_full, .o_rx_overwrite, .o_tx_sync_seen, .o_rx_sync_seen, .i_tx_clk_pin,
    .o_tx_clk_pin, .o_tx_clk_oe, .i_rx_clk_pin, .o_rx_clk_pin, .o_rx_clk_oe, .i_tx_frame_pin,
    .o_tx_frame_pin, .o_tx_frame_oe, .i_rx_frame_pin, .o_rx_frame_pin, .o_rx_frame_oe, .o_tx_data_pin,
    .i_rx_data_pin);

  sst_codec_model codec (.i_tx_clk(i_tx_clk_pin), .i_tx_data(o_tx_data_pin), .o_rx_clk(codec_rk),
    .o_rx_frame(codec_rf), .o_rx_data(codec_rd), .o_tx_capture(cap));

  always #25 i_mclk = ~i_mclk;

  // longest path is the 4095 divider case, some 25k cycles
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      end_of_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic pin_of(input int mode);
    return (mode == 2) ? o_rx_clk_pin : o_tx_clk_pin;
  endfunction

  task push(input logic [31:0] w);
    @(negedge i_mclk);
    i_tx_valid = 1'b1;
    i_tx_word = w;
    @(posedge i_mclk);
    while (o_tx_ready !== 1'b1)
      @(posedge i_mclk);
    @(negedge i_mclk);
    i_tx_valid = 1'b0;
  endtask

  // mode 0: tx from divider, 1: tx from rx clock, 2: rx from tx clock
  task automatic div_case(input logic [11:0] n, input logic inv, input int mode);
    int k, h, l;
    @(negedge i_mclk);
    i_div_ratio = n;
    i_tx_cki = inv;
    i_rx_cki = inv;
    i_tx_cks = (mode == 1) ? CKS_OTHER : CKS_DIV;
    i_rx_cks = (mode == 2) ? CKS_OTHER : CKS_DIV;
    i_tx_cko = (mode == 2) ? CKO_OFF : CKO_CONT;
    i_rx_cko = (mode == 2) ? CKO_CONT : CKO_OFF;
    repeat (2 * n + 4) @(posedge i_mclk);
    for (k = 0; pin_of(mode) !== 1'b0 && k < 9000; k++) @(posedge i_mclk);
    for (k = 0; pin_of(mode) !== 1'b1 && k < 9000; k++) @(posedge i_mclk);
    for (h = 0; pin_of(mode) === 1'b1 && h < 9000; h++) @(posedge i_mclk);
    for (l = 0; pin_of(mode) === 1'b0 && l < 9000; l++) @(posedge i_mclk);
    check(h, n);
    check(l, n);
    check((mode == 2) ? o_rx_clk_oe : o_tx_clk_oe, 1);
  endtask

  task automatic div_idle();
    int k, ones;
    @(negedge i_mclk);
    i_div_ratio = 12'h000;
    i_tx_cks = CKS_DIV;
    i_tx_cko = CKO_CONT;
    repeat (4) @(posedge i_mclk);
    ones = 0;
    for (k = 0; k < 20; k++)
    begin
      @(posedge i_mclk);
      ones += (o_tx_clk_pin !== 1'b0);
    end
    check(ones, 0);
  endtask

  task automatic tx_stream();
    int k;
    logic found;
    @(negedge i_mclk);
    i_div_ratio = 12'h006;
    i_tx_cks = CKS_DIV;
    i_tx_cki = 1'b0;
    i_tx_cko = CKO_XFER;
    i_rx_cks = CKS_PIN;
    i_rx_cko = CKO_OFF; // pin source never with continuous output
    i_tx_enable = 1'b1;
    i_tx_frame_sync_output_select = FS_HIGH_DATA;
    push(32'h000000a5);
    push(32'h0000003c);
    check(o_tx_drained, 0);
    for (k = 0; o_tx_drained !== 1'b1 && k < 400; k++) @(posedge i_mclk);
    check(k < 400, 1);
    check(o_tx_holding_free, 1);
    repeat (20) @(posedge i_mclk);
    found = 1'b0;
    for (k = 0; k <= 48; k++)
      if (cap[k +: 16] === 16'ha53c)
        found = 1'b1;
    check(found, 1);
    check(o_tx_clk_oe, 0);
  endtask

  task automatic tx_pulse();
    int k, h;
    @(negedge i_mclk);
    i_tx_frame_sync_output_select = FS_PULSE;
    i_tx_sync_length = 4'h2;
    push(32'h0000005a);
    check(o_tx_frame_oe, 1);
    for (k = 0; o_tx_frame_pin !== 1'b1 && k < 200; k++) @(posedge i_mclk);
    for (h = 0; o_tx_frame_pin === 1'b1 && h < 200; h++) @(posedge i_mclk);
    // start may fall anywhere within a bit, so allow one bit of slack
    check(h >= 25 && h <= 36, 1);
    check(o_tx_sync_seen, 1);
    for (k = 0; o_tx_drained !== 1'b1 && k < 400; k++) @(posedge i_mclk);
    @(negedge i_mclk);
    i_tx_frame_sync_output_select = FS_INPUT;
    i_tx_enable = 1'b0;
  endtask

  task rx_frames();
    @(negedge i_mclk);
    i_rx_enable = 1'b1;
    repeat (4) @(negedge i_mclk);
    codec.send_frame({4'hb, 8'h96}, 12, 4);
    repeat (3) @(posedge i_mclk);
    check(o_rx_holding_full, 1);
    check(o_rx_word, 32'h00000096);
    check(o_rx_sync_word, 16'h000b);
    check(o_rx_overwrite, 0);
    check(o_rx_sync_seen, 1);
    check(o_rx_frame_oe, 0);
    check(o_rx_frame_pin, 0);
    @(negedge i_mclk);
    codec.send_frame({4'h6, 8'h3c}, 12, 4);
    repeat (3) @(posedge i_mclk);
    check(o_rx_overwrite, 1);
    check(o_rx_word, 32'h0000003c);
    check(o_rx_sync_word, 16'h0006);
    @(negedge i_mclk);
    i_rx_read = 1'b1;
    @(negedge i_mclk);
    i_rx_read = 1'b0;
    check(o_rx_holding_full, 0);
    i_status_clear = 1'b1;
    @(negedge i_mclk);
    i_status_clear = 1'b0;
    check(o_rx_overwrite, 0);
    check(o_rx_sync_seen, 0);
    check(o_tx_sync_seen, 0);
  endtask

  // pattern in the top four bits starts the frame, then four sync bits and eight data bits
  task rx_compare();
    @(negedge i_mclk);
    i_rx_start = ST_CMP;
    i_rx_compare = 16'h000b;
    codec.send_frame(16'hb7e1, 16, 0);
    repeat (3) @(posedge i_mclk);
    check(o_rx_holding_full, 1);
    check(o_rx_word, 32'h000000e1);
    check(o_rx_sync_word, 16'h0007);
    check(o_rx_overwrite, 0);
    @(negedge i_mclk);
    i_rx_start = ST_CONT;
    repeat (2) @(negedge i_mclk);
    i_rx_enable = 1'b0;
  endtask

  initial
  begin
    {i_mclk, i_rstn, i_tx_cki, i_rx_cki, i_tx_sync_data_enable, i_tx_sync_edge_select, i_rx_sync_edge_select} = '0;
    {i_tx_enable, i_rx_enable, i_tx_valid, i_rx_read, i_status_clear} = '0;
    {fails, checks, cyc} = '0;
    i_div_ratio = 12'h000;
    i_tx_cks = CKS_DIV; // transmit pin never the source
    i_rx_cks = CKS_PIN;
    i_tx_cko = CKO_OFF;
    i_rx_cko = CKO_OFF;
    i_tx_start = ST_CONT;
    i_rx_start = ST_RISE;
    i_tx_frame_sync_output_select = FS_INPUT;
    i_rx_frame_sync_output_select = FS_INPUT;
    i_tx_sync_length = 4'h0;
    i_rx_sync_length = 4'h3;
    {i_tx_sttdly, i_tx_period, i_rx_period} = '0;
    i_rx_sttdly = 8'h04;
    i_tx_datlen = 5'h07;
    i_rx_datlen = 5'h07;
    i_tx_datdef = 1'b1;
    {i_tx_sync_word, i_rx_compare, i_tx_word} = '0;
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rstn = 1'b1;
    @(negedge i_mclk);
    check(o_tx_ready, 1);
    check(o_tx_holding_free, 1);
    check(o_tx_drained, 1);
    check(o_rx_holding_full, 0);
    div_case(12'h001, 1'b0, 0);
    div_case(12'h003, 1'b1, 0);
    div_case(12'hfff, 1'b0, 0);
    div_case(12'h002, 1'b0, 1);
    div_case(12'h003, 1'b0, 2);
    div_idle();
    tx_stream();
    tx_pulse();
    rx_frames();
    rx_compare();
    end_of_test();
  end
endmodule
`default_nettype wire
